// ### hdl/omc_top.sv
// Output macrocell array with AHB-Lite configuration slave.
// Assumes pins synchronous to hclk; the board resolves pad levels from cell_oe.
//
// Notes on behaviour
// - Sync bit 0 and architecture bit 1 select registered mode for all cells.
// - Polarity bit 0 gives active-low output, 1 gives active-high, every mode but off.
// - Registered mode: config bit 0 registered output, 1 combinatorial output or I/O.
// - Registered cells share one clock pin and one output-enable pin.
// - Registered outputs sum eight terms; combinatorial I/O cells sum seven.
// - Registered mode: clock and enable pins never reach the AND array.
// - Registered mode allows any mix of registered and I/O cells.
// - Sync bit 1 and architecture bit 1 select complex mode, all combinatorial.
// - Complex mode: outer cells are outputs only, no feedback path.
// - Complex mode: seven terms per cell, one term drives its enable.
// - Complex and simple modes feed clock and enable pins into the array.
// - Sync bit 1, architecture bit 0 select simple mode, outputs always enabled.
// - Simple mode: config bit 0 output, 1 dedicated input.
// - Simple mode: up to eight terms per output, polarity after the sum.
// - Simple mode: centre cells are outputs only, without feedback.
// - Signature word and per-term disable bits are provided.
// - Mode bits are shared; config and polarity bits are per cell.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module omc_top
	import omc_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	input  wire logic [NIN-1:0]   data_in,
	input  wire logic             clk_pin,
	input  wire logic             oe_n_pin,
	input  wire logic [NCELL-1:0] cell_in,
	output logic      [NCELL-1:0] cell_out,
	output logic      [NCELL-1:0] cell_oe
);

	typedef struct packed {
		omc_cfg_t                   cfg;
		logic [63:0]                sig;
		logic [NTERM-1:0]           tdis;
		logic [NTERM-1:0][NCOL-1:0] fuse;
		logic                       clk_pin_prev;
		logic [NCELL-1:0]           q;
		logic [NCELL-1:0]           pin_out;
		logic [NCELL-1:0]           pin_oe;
		omc_ap_t                    ap;
		logic                       rd_wait;
		logic [31:0]                rdata;
	} omc_state_t;

	omc_state_t state_reg;
	omc_state_t state_next;

	omc_mode_t        mode;
	logic [NSIG-1:0]  sig;
	logic [NTERM-1:0] term;
	logic [NCELL-1:0] cell_d;
	logic [NCELL-1:0] cell_val;
	logic [NCELL-1:0] cell_drive;
	logic [NCELL-1:0] cell_fb;
	logic [NCELL-1:0] cell_alt;

	assign mode = omc_mode_of(state_reg.cfg);

	// Clock and enable pins only reach spare feedback slots, and only
	// outside registered mode, so they can never act as logic there
	always_comb begin
		cell_alt            = '0;
		cell_alt[OUTER_LO]  = clk_pin;
		cell_alt[CENTRE_LO] = clk_pin;
		cell_alt[CENTRE_HI] = oe_n_pin;
		cell_alt[OUTER_HI]  = oe_n_pin;
	end

	assign sig = {cell_fb, data_in};

	omc_terms u_terms (
		.fuse (state_reg.fuse),
		.tdis (state_reg.tdis),
		.sig  (sig),
		.term (term)
	);

	genvar c;
	generate
		for (c = 0; c < NCELL; c++) begin : g_cell
			omc_cell #(
				.CELL (c)
			) u_cell (
				.mode     (mode),
				.cfg      (state_reg.cfg.cell_config_bit[c]),
				.pol      (state_reg.cfg.polarity_bit[c]),
				.terms    (term[c*NTERM_CELL +: NTERM_CELL]),
				.q        (state_reg.q[c]),
				.pin_in   (cell_in[c]),
				.alt_in   (cell_alt[c]),
				.oe_n_pin (oe_n_pin),
				.d        (cell_d[c]),
				.out_val  (cell_val[c]),
				.drive    (cell_drive[c]),
				.fb       (cell_fb[c])
			);
		end
	endgenerate

	function automatic logic [31:0] read_word(input omc_state_t s, input omc_mode_t m,
		input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		w = '0;
		if (omc_array_hit(a)) begin
			w = s.fuse[a[ARRAY_IDX_MSB:ARRAY_IDX_LSB]];
		end else begin
			unique case (a)
				ADDR_CTRL: begin
					w[CTRL_SYNC_BIT]                 = s.cfg.sync_mode_bit;
					w[CTRL_ARCH_BIT]                 = s.cfg.global_arch_bit;
					w[CTRL_CFG_LSB +: NCELL]         = s.cfg.cell_config_bit;
					w[CTRL_POL_LSB +: NCELL]         = s.cfg.polarity_bit;
				end
				ADDR_SIG_LO:  w = s.sig[31:0];
				ADDR_SIG_HI:  w = s.sig[63:32];
				ADDR_TDIS_LO: w = s.tdis[31:0];
				ADDR_TDIS_HI: w = s.tdis[63:32];
				ADDR_STATUS: begin
					w[STAT_MODE_LSB +: 2]     = m;
					w[STAT_Q_LSB +: NCELL]    = s.q;
					w[STAT_OE_LSB +: NCELL]   = s.pin_oe;
					w[STAT_OUT_LSB +: NCELL]  = s.pin_out;
				end
				default: w = '0;
			endcase
		end
		return w;
	endfunction

	logic addr_phase;

	assign addr_phase = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));

	always_comb begin
		state_next              = state_reg;
		state_next.clk_pin_prev = clk_pin;

		// Cell registers only run on a sampled rising edge of the clock pin
		if ((mode == OMC_MODE_REG) && clk_pin && !state_reg.clk_pin_prev) begin
			for (int i = 0; i < NCELL; i++) begin
				if (!state_reg.cfg.cell_config_bit[i]) begin
					state_next.q[i] = cell_d[i];
				end
			end
		end

		// Pin outputs come from flops: one hclk of latency after the array
		state_next.pin_out = cell_val;
		state_next.pin_oe  = cell_drive;

		// Write data phase
		if (state_reg.ap.wr && state_reg.ap.hit) begin
			if (omc_array_hit(state_reg.ap.addr)) begin
				state_next.fuse[state_reg.ap.addr[ARRAY_IDX_MSB:ARRAY_IDX_LSB]] = hwdata;
			end else begin
				unique case (state_reg.ap.addr)
					ADDR_CTRL: begin
						state_next.cfg.sync_mode_bit   = hwdata[CTRL_SYNC_BIT];
						state_next.cfg.global_arch_bit = hwdata[CTRL_ARCH_BIT];
						state_next.cfg.cell_config_bit = hwdata[CTRL_CFG_LSB +: NCELL];
						state_next.cfg.polarity_bit    = hwdata[CTRL_POL_LSB +: NCELL];
					end
					ADDR_SIG_LO:  state_next.sig[31:0]   = hwdata;
					ADDR_SIG_HI:  state_next.sig[63:32]  = hwdata;
					ADDR_TDIS_LO: state_next.tdis[31:0]  = hwdata;
					ADDR_TDIS_HI: state_next.tdis[63:32] = hwdata;
					default: ;
				endcase
			end
		end
		state_next.ap.wr = 1'b0;

		// Read takes one wait state so a read right after a write sees the new value
		if (state_reg.rd_wait) begin
			state_next.rdata   = state_reg.ap.hit ? read_word(state_reg, mode, state_reg.ap.addr) : '0;
			state_next.rd_wait = 1'b0;
		end

		if (addr_phase) begin
			state_next.ap.wr   = hwrite && (hsize == HSIZE_WORD);
			state_next.ap.hit  = (haddr[31:ADDR_W] == '0);
			state_next.ap.addr = haddr[ADDR_W-1:0];
			state_next.rd_wait = !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg                     <= '0;
			state_reg.cfg.sync_mode_bit   <= RST_SYNC;
			state_reg.cfg.global_arch_bit <= RST_ARCH;
			state_reg.cfg.cell_config_bit <= RST_CFG;
			state_reg.cfg.polarity_bit    <= RST_POL;
			state_reg.sig                 <= RST_SIG;
			state_reg.tdis                <= RST_TDIS;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout = !state_reg.rd_wait;
	assign hresp     = 1'b0;
	assign hrdata    = state_reg.rdata;
	assign cell_out  = state_reg.pin_out;
	assign cell_oe   = state_reg.pin_oe;

endmodule
`default_nettype wire

// ### common/omc_pkg.sv
// Constants, types and decode helpers for the output macrocell array block.
// Assumes one 100 MHz bus clock; all pins are synchronous to it.
package omc_pkg;

	localparam int NCELL      = 8;
	localparam int NTERM_CELL = 8;
	localparam int NTERM      = 64;
	localparam int NIN        = 8;
	localparam int NSIG       = 16;
	localparam int NCOL       = 32;

	// Cell positions: cell 0 is the upper outer pin, cell 7 the lower outer pin
	localparam int OUTER_LO   = 0;
	localparam int OUTER_HI   = 7;
	localparam int CENTRE_LO  = 3;
	localparam int CENTRE_HI  = 4;
	localparam int OE_TERM    = 0;

	// Register byte addresses
	localparam logic [9:0] ADDR_CTRL       = 10'h000;
	localparam logic [9:0] ADDR_SIG_LO     = 10'h004;
	localparam logic [9:0] ADDR_SIG_HI     = 10'h008;
	localparam logic [9:0] ADDR_TDIS_LO    = 10'h00c;
	localparam logic [9:0] ADDR_TDIS_HI    = 10'h010;
	localparam logic [9:0] ADDR_STATUS     = 10'h014;
	localparam logic [9:0] ADDR_ARRAY_BASE = 10'h100;
	localparam logic [9:0] ADDR_ARRAY_MASK = 10'h300;
	localparam int         ARRAY_IDX_LSB   = 2;
	localparam int         ARRAY_IDX_MSB   = 7;
	localparam int         ADDR_W          = 10;

	// Control word fields
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_ARCH_BIT = 1;
	localparam int CTRL_CFG_LSB  = 8;
	localparam int CTRL_POL_LSB  = 16;

	// Status word fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_Q_LSB    = 8;
	localparam int STAT_OE_LSB   = 16;
	localparam int STAT_OUT_LSB  = 24;

	// Reset values
	localparam logic        RST_SYNC = 1'b1;
	localparam logic        RST_ARCH = 1'b0;
	localparam logic [7:0]  RST_CFG  = 8'hff;
	localparam logic [7:0]  RST_POL  = 8'h00;
	localparam logic [63:0] RST_SIG  = 64'h0000_0000_0000_0000; // Arbitrary value
	localparam logic [63:0] RST_TDIS = 64'h0000_0000_0000_0000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [1:0] {
		OMC_MODE_OFF,
		OMC_MODE_SIMPLE,
		OMC_MODE_COMPLEX,
		OMC_MODE_REG
	} omc_mode_t;

	typedef struct packed {
		logic             sync_mode_bit;
		logic             global_arch_bit;
		logic [NCELL-1:0] cell_config_bit;
		logic [NCELL-1:0] polarity_bit;
	} omc_cfg_t;

	typedef struct packed {
		logic              wr;
		logic              hit;
		logic [ADDR_W-1:0] addr;
	} omc_ap_t;

	function automatic omc_mode_t omc_mode_of(input omc_cfg_t c);
		omc_mode_t m;
		m = OMC_MODE_OFF;
		unique case ({c.sync_mode_bit, c.global_arch_bit})
			2'b01: m = OMC_MODE_REG;
			2'b11: m = OMC_MODE_COMPLEX;
			2'b10: m = OMC_MODE_SIMPLE;
			2'b00: m = OMC_MODE_OFF;
		endcase
		return m;
	endfunction

	function automatic logic omc_array_hit(input logic [ADDR_W-1:0] a);
		return (a & ADDR_ARRAY_MASK) == ADDR_ARRAY_BASE;
	endfunction

endpackage

// ### hdl/omc_terms.sv
// AND array: 64 product terms over 16 signals in true and complement form.
// Assumes fuse words and term-disable bits held stable by the parent.
`timescale 1ns/1ps
`default_nettype none
module omc_terms
	import omc_pkg::*;
(
	input  wire logic [NTERM-1:0][NCOL-1:0] fuse,
	input  wire logic [NTERM-1:0]           tdis,
	input  wire logic [NSIG-1:0]            sig,
	output logic      [NTERM-1:0]           term
);
	logic [NCOL-1:0] lit;

	genvar k, t;
	generate
		for (k = 0; k < NSIG; k++) begin : g_lit
			assign lit[2*k]   = sig[k];
			assign lit[2*k+1] = ~sig[k];
		end
		// A set fuse bit joins that column; a disabled term drops out of its sum
		for (t = 0; t < NTERM; t++) begin : g_term
			assign term[t] = ~tdis[t] & (&(~fuse[t] | lit));
		end
	endgenerate
endmodule
`default_nettype wire

// ### hdl/omc_cell.sv
// One output macrocell: sum, polarity, drive enable and feedback selection.
// Assumes the parent holds the cell register and passes its value in q.
`timescale 1ns/1ps
`default_nettype none
module omc_cell
	import omc_pkg::*;
#(
	parameter int CELL = 0
)
(
	input  wire omc_mode_t             mode,
	input  wire logic                  cfg,
	input  wire logic                  pol,
	input  wire logic [NTERM_CELL-1:0] terms,
	input  wire logic                  q,
	input  wire logic                  pin_in,
	input  wire logic                  alt_in,
	input  wire logic                  oe_n_pin,
	output logic                       d,
	output logic                       out_val,
	output logic                       drive,
	output logic                       fb
);
	localparam bit OUTER  = (CELL == OUTER_LO) || (CELL == OUTER_HI);
	localparam bit CENTRE = (CELL == CENTRE_LO) || (CELL == CENTRE_HI);

	logic sum_all;
	logic sum_seven;

	always_comb begin
		sum_all   = |terms;
		sum_seven = |terms[NTERM_CELL-1:OE_TERM+1];
		d         = sum_all;
		out_val   = 1'b0;
		drive     = 1'b0;
		fb        = 1'b0;
		unique case (mode)
			OMC_MODE_REG: begin
				if (!cfg) begin
					out_val = pol ? q : ~q;
					drive   = ~oe_n_pin;
					fb      = q;
				end else begin
					out_val = pol ? sum_seven : ~sum_seven;
					drive   = terms[OE_TERM];
					fb      = pin_in;
				end
			end
			OMC_MODE_COMPLEX: begin
				out_val = pol ? sum_seven : ~sum_seven;
				drive   = terms[OE_TERM];
				fb      = OUTER ? alt_in : pin_in;
			end
			OMC_MODE_SIMPLE: begin
				// Centre slots are free here, so the two control pins ride on them
				if (CENTRE || !cfg) begin
					out_val = pol ? sum_all : ~sum_all;
					drive   = 1'b1;
				end
				fb = CENTRE ? alt_in : pin_in;
			end
			OMC_MODE_OFF: begin
				fb = pin_in;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### verification/omc_board.sv
// Board model: resolves each macrocell pad.
// Assumes the board drives every pad a cell leaves undriven.
`timescale 1ns/1ps
`default_nettype none
module omc_board
	import omc_pkg::*;
(
	input  wire logic [NCELL-1:0] cell_out,
	input  wire logic [NCELL-1:0] cell_oe,
	input  wire logic [NCELL-1:0] board,
	output logic      [NCELL-1:0] cell_in
);
	// Cell wins; contention not modelled
	assign cell_in = (cell_out & cell_oe) | (board & ~cell_oe);
endmodule
`default_nettype wire

// ### verification/omc_top_asserts.sv
// Port checks for the macrocell array top.
// Assumes hready tied to hreadyout, one hclk domain.
`timescale 1ns/1ps
`default_nettype none
module omc_top_asserts
	import omc_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [31:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [2:0]       hsize,
	input wire logic [31:0]      hwdata,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic             clk_pin,
	input wire logic             oe_n_pin,
	input wire logic [NCELL-1:0] cell_out,
	input wire logic [NCELL-1:0] cell_oe
);
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_q;
	logic        wr_pend;
	logic [2:0]  age;
	wire         vld   = (age == 3'h4);
	wire         rd_go = hsel && hready && htrans[1] && !hwrite;
	wire         wr_go = hsel && hready && htrans[1] && hwrite;
	wire         reg0  = vld && ctrl_q[1:0] == 2'b10 && !ctrl_q[8];
	wire         simp  = vld && ctrl_q[1:0] == 2'b01;

	// Shadow control word; ctrl_q lags by the output register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= {8'h00, RST_POL, RST_CFG, 6'h00, RST_ARCH, RST_SYNC};
			ctrl_q   <= {8'h00, RST_POL, RST_CFG, 6'h00, RST_ARCH, RST_SYNC};
			wr_pend  <= 1'b0;
			age      <= 3'h0;
		end else begin
			if (hready) wr_pend <= wr_go && hsize == HSIZE_WORD && haddr == 32'h0;
			if (wr_pend && hready) ctrl_reg <= hwdata;
			ctrl_q <= ctrl_reg;
			if (age != 3'h4) age <= age + 3'h1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (wr_go |=> hreadyout)
		else $error("write stalled");
	reg_oe_a: assert property (reg0 |-> cell_oe[0] == !$past(oe_n_pin))
		else $error("registered enable wrong");
	reg_hold_a: assert property (reg0 && ctrl_q == $past(ctrl_q) && !($past(clk_pin, 2) && !$past(clk_pin, 3))
		|-> $stable(cell_out[0]))
		else $error("registered output moved without clock");
	simple_centre_a: assert property (simp |-> cell_oe[4:3] == 2'b11)
		else $error("centre cell not driving");
	simple_input_a: assert property (simp && ctrl_q[8] |-> !cell_oe[0])
		else $error("input cell driving");
	simple_out_a: assert property (simp && !ctrl_q[9] |-> cell_oe[1])
		else $error("simple output not enabled");

	cover property (rd_go);
	cover property (reg0 && $rose(cell_out[0]));
	cover property (simp && !ctrl_q[9]);
endmodule

bind omc_top omc_top_asserts i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hreadyout, .hresp, .clk_pin, .oe_n_pin, .cell_out, .cell_oe);
`default_nettype wire

// ### verification/omc_top_tb.sv
// Bench for the macrocell array over AHB-Lite.
// Assumes the board model resolves pads.
`timescale 1ns/1ps
`default_nettype none
module omc_top_tb
	import omc_pkg::*;
;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b0;
	logic             hwrite = 1'b0;
	logic             clk_pin = 1'b0;
	logic             oe_n_pin = 1'b0;
	logic [31:0]      haddr = 32'h0;
	logic [31:0]      hwdata = 32'h0;
	logic [31:0]      hrdata;
	logic [31:0]      rd_data;
	logic [1:0]       htrans = 2'h0;
	logic [2:0]       hsize = 3'h2;
	logic [NIN-1:0]   data_in = 8'h00;
	logic [NCELL-1:0] board = 8'h00;
	logic [NCELL-1:0] cell_in;
	logic [NCELL-1:0] cell_out;
	logic [NCELL-1:0] cell_oe;
	logic             hreadyout;
	logic             hresp;
	int               err_count = 0;
	int               n_checks = 0;

	always #5 hclk = ~hclk;

	omc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .data_in, .clk_pin, .oe_n_pin, .cell_in, .cell_out, .cell_oe);
	omc_board i_board (.cell_out, .cell_oe, .board, .cell_in);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Single word transfer; read data lands in rd_data
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_data = hrdata;
	endtask

	task automatic pulse();
		clk_pin <= 1'b1;
		@(posedge hclk);
		clk_pin <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	function automatic logic [1:0] mode_exp(input logic [1:0] sa);
		return sa[1] ? (sa[0] ? 2'h2 : 2'h3) : (sa[0] ? 2'h1 : 2'h0);
	endfunction

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100us;
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0, 32'h0);
		chk("ctrl", rd_data, {8'h00, RST_POL, RST_CFG, 6'h00, RST_ARCH, RST_SYNC});
		bus(1'b0, 32'h14, 32'h0);
		chk("status", rd_data, 32'h0018_0001);
		bus(1'b1, 32'h4, 32'h0123_4567);
		bus(1'b1, 32'h8, 32'h89ab_cdef);
		bus(1'b0, 32'h4, 32'h0);
		chk("sig lo", rd_data, 32'h0123_4567);
		bus(1'b0, 32'h8, 32'h0);
		chk("sig hi", rd_data, 32'h89ab_cdef);
		bus(1'b0, 32'h18, 32'h0);
		chk("unmapped", rd_data, 32'h0);
		bus(1'b1, 32'h404, 32'hffff_ffff);
		bus(1'b0, 32'h4, 32'h0);
		chk("high addr", rd_data, 32'h0123_4567);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 32'h0, {24'h0000ff, 6'h0, m[1:0]});
			bus(1'b0, 32'h14, 32'h0);
			chk("mode", {30'h0, rd_data[1:0]}, {30'h0, mode_exp(m[1:0])});
		end
		// Cell 1 sums term 9 only; term 8 off
		bus(1'b1, 32'hc, 32'h0000_fdfe);
		bus(1'b1, 32'h124, 32'h1);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 32'h0, {8'h00, 6'h0, k[1], 1'b0, 8'h00, 8'h01});
			data_in <= {7'h0, k[0]};
			repeat (3) @(posedge hclk);
			chk("simple sum", {31'h0, cell_out[1]}, {31'h0, k[1] ? k[0] : !k[0]});
		end
		bus(1'b1, 32'hc, 32'h0000_fffe);
		repeat (3) @(posedge hclk);
		chk("term off", {31'h0, cell_out[1]}, 32'h0);
		bus(1'b1, 32'hc, 32'h0000_fdfe);
		bus(1'b1, 32'h124, 32'h0040_0000);
		for (int c = 0; c < 2; c++) begin
			clk_pin <= c[0];
			repeat (3) @(posedge hclk);
			chk("simple clk in", {31'h0, cell_out[1]}, {31'h0, c[0]});
		end
		bus(1'b1, 32'h0, 32'h0002_ff02);
		for (int c = 0; c < 2; c++) begin
			clk_pin <= c[0];
			repeat (3) @(posedge hclk);
			chk("reg clk out", {31'h0, cell_out[1]}, 32'h0);
			chk("reg io oe", {31'h0, cell_oe[1]}, 32'h0);
		end
		bus(1'b1, 32'h0, 32'h0002_ff03);
		bus(1'b1, 32'h124, 32'h0001_0000);
		for (int c = 0; c < 2; c++) begin
			clk_pin <= c[0];
			board <= {8{!c[0]}};
			repeat (3) @(posedge hclk);
			chk("complex slot", {31'h0, cell_out[1]}, {31'h0, c[0]});
		end
		bus(1'b1, 32'hc, 32'h0000_fcfe);
		repeat (3) @(posedge hclk);
		chk("complex oe on", {31'h0, cell_oe[1]}, 32'h1);
		// Cell 0 registered, active high, D = data_in[1]
		clk_pin <= 1'b0;
		bus(1'b1, 32'hc, 32'h0000_fdfe);
		bus(1'b1, 32'h100, 32'h4);
		bus(1'b1, 32'h0, 32'h0001_fe02);
		data_in <= 8'h02;
		pulse();
		chk("reg q", {31'h0, cell_out[0]}, 32'h1);
		chk("reg oe", {31'h0, cell_oe[0]}, 32'h1);
		data_in <= 8'h00;
		repeat (3) @(posedge hclk);
		chk("reg hold", {31'h0, cell_out[0]}, 32'h1);
		oe_n_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("reg oe off", {31'h0, cell_oe[0]}, 32'h0);
		oe_n_pin <= 1'b0;
		pulse();
		chk("reg q low", {31'h0, cell_out[0]}, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
